// file: core/isac_top.sv
// slave-address recognition, command register and status monitor of a two-wire bus controller
// assumes an AHB-Lite master on clk and open-drain scl/sda resolved outside
`timescale 1ns/100ps
`include "isac_map.svh"

// What this block does
// - seven-bit own address sits in bits 7:1 of the address register
// - recognition on: compare first seven bits, direction bit picks role
// - on own-address match with detection enabled, pull sda low at ninth clock
// - once addressed, stay slave until stop or repeated start
// - address mismatch: leave lines released until stop or repeated start
// - all-zero address byte with detection enabled: acknowledge, become receiver
// - detection disabled: no address or general-call acknowledge; free format still acknowledges and receives
// - free format: first byte is data, acknowledge, receive until stop/restart
// - command bit 7 selects master (1) or slave (0)
// - command bit 6 selects transmitter (1) or receiver (0)
// - command bit 5 requests start (1) or stop (0)
// - writing 1 to command bit 4 clears the service request
// - key writes 10 then 01 give a one-cycle internal reset pulse
// - soft reset releases lines, reinitialises all but enable
// - status bits 7,6,5 show master, transmitter and bus busy
// - status bit 4 is 0 while request pending with scl held low
// - status bits 3,2,1 show arbitration lost, address match, general call
// - status bit 0 shows the most recently received bus bit
// - busy sets on start, clears on stop; no start while busy
// - match flag clears on request release, stays clear until next match
// - general call sets both flags; general call flag holds until stop/restart
module isac_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe
);

  function automatic logic regIs(input logic [5:0] idx, input logic [7:0] off);
    return idx == off[7:2];
  endfunction

  isac_pkg::isac_access_type acc_reg;
  isac_pkg::isac_status_type status;
  isac_pkg::isac_slave_type slvState_reg;
  isac_pkg::isac_master_type mstState_reg;

  logic sclMeta_reg, sclSync_reg, sclDly_reg;
  logic sdaMeta_reg, sdaSync_reg, sdaDly_reg;
  logic sclRise, sclFall, startDet, stopDet;

  logic [6:0] ownAddr_reg;
  logic recogDisable_reg;
  logic slaveDetectDisable_reg;
  logic controllerEnable_reg;
  logic mst_reg, trx_reg, busBusy_reg, svcPending_reg;
  logic arbLost_reg, addrMatch_reg, genCall_reg, lastRxBit_reg;
  logic keyArmed_reg, softReset_reg;

  logic [7:0] shift_reg;
  logic [3:0] bitCnt_reg;
  logic slvSdaLow_reg;
  logic mstSdaLow_reg, mstSclLow_reg;
  logic [9:0] holdCnt_reg;

  logic cmdWr, cfgWr, oaWr, svcClear, slvRun, byteDone;
  logic addrHit, genCallHit, slaveAccept, freeAccept, svcSet;
  logic startReq, stopReq, holdDone;
  logic [31:0] readData;

  // two-stage synchronisers; edge logic reads only the second stage onward
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclMeta_reg <= 1'h1;
      sclSync_reg <= 1'h1;
      sclDly_reg <= 1'h1;
      sdaMeta_reg <= 1'h1;
      sdaSync_reg <= 1'h1;
      sdaDly_reg <= 1'h1;
    end else begin
      sclMeta_reg <= sclIn;
      sclSync_reg <= sclMeta_reg;
      sclDly_reg <= sclSync_reg;
      sdaMeta_reg <= sdaIn;
      sdaSync_reg <= sdaMeta_reg;
      sdaDly_reg <= sdaSync_reg;
    end
  end

  assign sclRise = sclSync_reg & ~sclDly_reg;
  assign sclFall = ~sclSync_reg & sclDly_reg;
  assign startDet = sclSync_reg & sclDly_reg & sdaDly_reg & ~sdaSync_reg;
  assign stopDet = sclSync_reg & sclDly_reg & ~sdaDly_reg & sdaSync_reg;

  // every transfer takes one wait state so a read always sees earlier writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_reg <= '0;
      hreadyout <= 1'h1;
      hresp <= 1'h0;
      hrdata <= 32'h0;
    end else begin
      if (hready && hsel && htrans[1]) begin
        acc_reg.idx <= haddr[7:2];
        acc_reg.wr <= hwrite;
        acc_reg.rd <= !hwrite;
        hreadyout <= 1'h0;
      end else begin
        acc_reg <= '0;
        hreadyout <= 1'h1;
      end
      if (acc_reg.rd) begin
        hrdata <= readData;
      end
    end
  end

  assign cmdWr = acc_reg.wr && regIs(acc_reg.idx, `ISAC_OFF_CMD);
  assign cfgWr = acc_reg.wr && regIs(acc_reg.idx, `ISAC_OFF_CONFIG);
  assign oaWr = acc_reg.wr && regIs(acc_reg.idx, `ISAC_OFF_OWN_ADDR);
  assign svcClear = cmdWr && hwdata[`ISAC_CMD_PIN];

  always_comb begin
    status.mst = mst_reg;
    status.trx = trx_reg;
    status.busBusy = busBusy_reg;
    status.pinFree = !svcPending_reg;
    status.arbitrationLost = arbLost_reg;
    status.addrMatchFlag = addrMatch_reg;
    status.generalCallFlag = genCall_reg;
    status.lastRxBit = lastRxBit_reg;
    readData = 32'h0;
    if (regIs(acc_reg.idx, `ISAC_OFF_STATUS)) begin
      readData[7:0] = status;
    end else if (regIs(acc_reg.idx, `ISAC_OFF_OWN_ADDR)) begin
      readData[7:0] = {ownAddr_reg, recogDisable_reg};
    end else if (regIs(acc_reg.idx, `ISAC_OFF_CONFIG)) begin
      readData[`ISAC_CFG_SLV_DET_DIS] = slaveDetectDisable_reg;
    end
  end

  // soft reset key: prime on 10, fire on a following 01, anything else drops the key
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      keyArmed_reg <= 1'h0;
      softReset_reg <= 1'h0;
    end else begin
      softReset_reg <= 1'h0;
      if (cmdWr) begin
        if (hwdata[`ISAC_CMD_KEY_HI:`ISAC_CMD_KEY_LO] == `ISAC_KEY_PRIME) begin
          keyArmed_reg <= 1'h1;
        end else if (hwdata[`ISAC_CMD_KEY_HI:`ISAC_CMD_KEY_LO] == `ISAC_KEY_FIRE &&
                     keyArmed_reg) begin
          keyArmed_reg <= 1'h0;
          softReset_reg <= 1'h1;
        end else begin
          keyArmed_reg <= 1'h0;
        end
      end
    end
  end

  // enable survives the soft reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      controllerEnable_reg <= 1'h0;
    end else if (cmdWr) begin
      controllerEnable_reg <= hwdata[`ISAC_CMD_ENABLE];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ownAddr_reg <= `ISAC_RST_OWN_ADDR;
      recogDisable_reg <= 1'h0;
      slaveDetectDisable_reg <= 1'h0;
    end else if (softReset_reg) begin
      ownAddr_reg <= `ISAC_RST_OWN_ADDR;
      recogDisable_reg <= 1'h0;
      slaveDetectDisable_reg <= 1'h0;
    end else begin
      if (oaWr) begin
        ownAddr_reg <= hwdata[`ISAC_OA_ADDR_HI:`ISAC_OA_ADDR_LO];
        recogDisable_reg <= hwdata[`ISAC_OA_RECOG_DIS];
      end
      if (cfgWr) begin
        slaveDetectDisable_reg <= hwdata[`ISAC_CFG_SLV_DET_DIS];
      end
    end
  end

  // slave engine runs only when enabled, in slave mode and between bus conditions
  assign slvRun = controllerEnable_reg && !mst_reg && !softReset_reg && !startDet && !stopDet;
  assign byteDone = sclFall && bitCnt_reg == `ISAC_BITS_PER_BYTE;
  assign addrHit = shift_reg[7:1] == ownAddr_reg;
  assign genCallHit = shift_reg == 8'h00;
  assign freeAccept = slvRun && slvState_reg == isac_pkg::slvAddr && byteDone &&
                      recogDisable_reg;
  assign slaveAccept = slvRun && slvState_reg == isac_pkg::slvAddr && byteDone &&
                       !recogDisable_reg && !slaveDetectDisable_reg &&
                       (addrHit || genCallHit);
  assign svcSet = slvRun && slvState_reg == isac_pkg::slvAck && sclFall;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slvState_reg <= isac_pkg::slvIdle;
      shift_reg <= 8'h00;
      bitCnt_reg <= 4'h0;
      slvSdaLow_reg <= 1'h0;
    end else if (softReset_reg || !controllerEnable_reg || mst_reg || stopDet) begin
      slvState_reg <= isac_pkg::slvIdle;
      bitCnt_reg <= 4'h0;
      slvSdaLow_reg <= 1'h0;
    end else if (startDet) begin
      slvState_reg <= isac_pkg::slvAddr;
      bitCnt_reg <= 4'h0;
      slvSdaLow_reg <= 1'h0;
    end else begin
      case (slvState_reg)
        isac_pkg::slvAddr, isac_pkg::slvData: begin
          if (sclRise) begin
            shift_reg <= {shift_reg[6:0], sdaSync_reg};
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end
          if (byteDone) begin
            bitCnt_reg <= 4'h0;
            if (slvState_reg == isac_pkg::slvData) begin
              slvSdaLow_reg <= !trx_reg;
              slvState_reg <= isac_pkg::slvAck;
            end else if (freeAccept || slaveAccept) begin
              slvSdaLow_reg <= 1'h1;
              slvState_reg <= isac_pkg::slvAck;
            end else begin
              slvState_reg <= isac_pkg::slvIgnore;
            end
          end
        end
        isac_pkg::slvAck: begin
          if (sclFall) begin
            slvSdaLow_reg <= 1'h0;
            slvState_reg <= isac_pkg::slvWait;
          end
        end
        isac_pkg::slvWait: begin
          if (!svcPending_reg) begin
            slvState_reg <= isac_pkg::slvData;
          end
        end
        isac_pkg::slvIdle, isac_pkg::slvIgnore: begin
          slvSdaLow_reg <= 1'h0;
        end
        default: begin
          slvState_reg <= isac_pkg::slvIdle;
        end
      endcase
    end
  end

  // set wins over a software clear landing in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      svcPending_reg <= 1'h0;
    end else if (softReset_reg || !controllerEnable_reg) begin
      svcPending_reg <= 1'h0;
    end else if (svcSet) begin
      svcPending_reg <= 1'h1;
    end else if (svcClear) begin
      svcPending_reg <= 1'h0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busBusy_reg <= 1'h0;
    end else if (softReset_reg) begin
      busBusy_reg <= 1'h0;
    end else if (startDet) begin
      busBusy_reg <= 1'h1;
    end else if (stopDet) begin
      busBusy_reg <= 1'h0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addrMatch_reg <= 1'h0;
    end else if (softReset_reg || startDet || stopDet) begin
      addrMatch_reg <= 1'h0;
    end else if (slaveAccept) begin
      addrMatch_reg <= 1'h1;
    end else if (svcClear && slvState_reg == isac_pkg::slvWait) begin
      addrMatch_reg <= 1'h0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      genCall_reg <= 1'h0;
    end else if (softReset_reg || startDet || stopDet) begin
      genCall_reg <= 1'h0;
    end else if (slaveAccept && genCallHit) begin
      genCall_reg <= 1'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lastRxBit_reg <= 1'h0;
    end else if (softReset_reg) begin
      lastRxBit_reg <= 1'h0;
    end else if (sclRise && controllerEnable_reg) begin
      lastRxBit_reg <= sdaSync_reg;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mst_reg <= 1'h0;
    end else if (softReset_reg) begin
      mst_reg <= 1'h0;
    end else if (cmdWr) begin
      mst_reg <= hwdata[`ISAC_CMD_MST];
    end
  end

  // hardware role choice on acceptance outranks a software write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trx_reg <= 1'h0;
    end else if (softReset_reg) begin
      trx_reg <= 1'h0;
    end else if (freeAccept) begin
      trx_reg <= 1'h0;
    end else if (slaveAccept) begin
      trx_reg <= genCallHit ? 1'h0 : shift_reg[0];
    end else if (cmdWr) begin
      trx_reg <= hwdata[`ISAC_CMD_TRX];
    end
  end

  // start and stop generation only; data clocking is not part of this block
  assign startReq = cmdWr && hwdata[`ISAC_CMD_START] && hwdata[`ISAC_CMD_MST] &&
                    controllerEnable_reg && !busBusy_reg;
  assign stopReq = cmdWr && !hwdata[`ISAC_CMD_START];
  assign holdDone = holdCnt_reg == 10'(`ISAC_HOLD_CYC - 1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mstState_reg <= isac_pkg::mstIdle;
      mstSdaLow_reg <= 1'h0;
      mstSclLow_reg <= 1'h0;
      holdCnt_reg <= 10'h000;
    end else if (softReset_reg || !controllerEnable_reg) begin
      mstState_reg <= isac_pkg::mstIdle;
      mstSdaLow_reg <= 1'h0;
      mstSclLow_reg <= 1'h0;
      holdCnt_reg <= 10'h000;
    end else begin
      holdCnt_reg <= holdDone ? 10'h000 : holdCnt_reg + 10'h001;
      case (mstState_reg)
        isac_pkg::mstIdle: begin
          holdCnt_reg <= 10'h000;
          if (startReq) begin
            mstSdaLow_reg <= 1'h1;
            mstState_reg <= isac_pkg::mstStart;
          end
        end
        isac_pkg::mstStart: begin
          if (holdDone) begin
            mstSclLow_reg <= 1'h1;
            mstState_reg <= isac_pkg::mstHold;
          end
        end
        isac_pkg::mstHold: begin
          holdCnt_reg <= 10'h000;
          if (stopReq) begin
            mstSclLow_reg <= 1'h0;
            mstState_reg <= isac_pkg::mstStopLow;
          end
        end
        isac_pkg::mstStopLow: begin
          if (holdDone) begin
            mstSdaLow_reg <= 1'h0;
            mstState_reg <= isac_pkg::mstStopRel;
          end
        end
        isac_pkg::mstStopRel: begin
          if (holdDone) begin
            mstState_reg <= isac_pkg::mstIdle;
          end
        end
        default: begin
          mstState_reg <= isac_pkg::mstIdle;
        end
      endcase
    end
  end

  // another master still pulling sda after our stop release means we lost the bus
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arbLost_reg <= 1'h0;
    end else if (softReset_reg || startReq) begin
      arbLost_reg <= 1'h0;
    end else if (mstState_reg == isac_pkg::mstStopRel && holdDone && !sdaSync_reg) begin
      arbLost_reg <= 1'h1;
    end
  end

  // open-drain pins: drive low only, release on soft reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclOut <= 1'h0;
      sdaOut <= 1'h0;
      sclOe <= 1'h0;
      sdaOe <= 1'h0;
    end else begin
      sclOut <= 1'h0;
      sdaOut <= 1'h0;
      sclOe <= !softReset_reg && (mstSclLow_reg || svcPending_reg);
      sdaOe <= !softReset_reg && (mstSdaLow_reg || slvSdaLow_reg);
    end
  end

endmodule // isac_top

// file: core/isac_map.svh
// register offsets, field positions, reset values and timing counts
// assumes a 200 MHz peripheral clock and 32-bit word-aligned registers
`ifndef ISAC_MAP_SVH
`define ISAC_MAP_SVH

`define ISAC_OFF_CONFIG 8'h00
`define ISAC_OFF_OWN_ADDR 8'h08
`define ISAC_OFF_CMD 8'h0c
`define ISAC_OFF_STATUS 8'h0c

`define ISAC_CFG_SLV_DET_DIS 3
`define ISAC_OA_ADDR_HI 7
`define ISAC_OA_ADDR_LO 1
`define ISAC_OA_RECOG_DIS 0

`define ISAC_CMD_MST 7
`define ISAC_CMD_TRX 6
`define ISAC_CMD_START 5
`define ISAC_CMD_PIN 4
`define ISAC_CMD_ENABLE 3
`define ISAC_CMD_KEY_HI 1
`define ISAC_CMD_KEY_LO 0
`define ISAC_KEY_PRIME 2'h2
`define ISAC_KEY_FIRE 2'h1

`define ISAC_RST_OWN_ADDR 7'h00
`define ISAC_RST_PIN_FREE 1'h1

`define ISAC_CLK_NS 5
`define ISAC_T_HOLD_NS 4700
`define ISAC_HOLD_CYC ((`ISAC_T_HOLD_NS + `ISAC_CLK_NS - 1) / `ISAC_CLK_NS)
`define ISAC_BITS_PER_BYTE 4'h8

`endif

// file: core/isac_pkg.sv
// types shared by the slave-address / command / status block
// assumes the constants in isac_map.svh
package isac_pkg;

  typedef struct packed {
    logic mst;
    logic trx;
    logic busBusy;
    logic pinFree;
    logic arbitrationLost;
    logic addrMatchFlag;
    logic generalCallFlag;
    logic lastRxBit;
  } isac_status_type;

  typedef struct packed {
    logic [5:0] idx;
    logic wr;
    logic rd;
  } isac_access_type;

  typedef enum logic [2:0] {
    slvIdle,
    slvAddr,
    slvAck,
    slvWait,
    slvData,
    slvIgnore
  } isac_slave_type;

  typedef enum logic [2:0] {
    mstIdle,
    mstStart,
    mstHold,
    mstStopLow,
    mstStopRel
  } isac_master_type;

endpackage

// file: tb/isac_checker.sv
// port-level assertions for isac_top, attached by bind
// assumes sclIn/sdaIn carry the resolved open-drain wire levels
`timescale 1ns/100ps
module isac_checker (
  input logic clk,
  input logic nrst,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic hready,
  input logic hreadyout,
  input logic [31:0] hrdata,
  input logic hresp,
  input logic sclIn,
  input logic sclOut,
  input logic sclOe,
  input logic sdaIn,
  input logic sdaOut,
  input logic sdaOe
);
  logic taken, rdPhase, cmdPhase, sclD, sdaD, busyW;
  logic [3:0] bitCnt, sinceCmd;
  assign taken = hsel && hready && htrans[1];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdPhase <= 1'b0;
      cmdPhase <= 1'b0;
      sinceCmd <= 4'hf;
    end else begin
      rdPhase <= taken && !hwrite;
      cmdPhase <= taken && hwrite && haddr[7:2] == 6'h03;
      if (cmdPhase) sinceCmd <= 4'h0;
      else if (sinceCmd != 4'hf) sinceCmd <= sinceCmd + 4'h1;
    end
  end
  // raw wire view: start/stop reset the count, scl rises count 1..9
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclD <= 1'b1;
      sdaD <= 1'b1;
      busyW <= 1'b0;
      bitCnt <= 4'h0;
    end else begin
      sclD <= sclIn;
      sdaD <= sdaIn;
      if (sclIn && sclD && sdaD != sdaIn) busyW <= sdaD;
      if (sclIn && sclD && sdaD != sdaIn) bitCnt <= 4'h0;
      else if (sclIn && !sclD) bitCnt <= (bitCnt == 4'h9) ? 4'h1 : bitCnt + 4'h1;
    end
  end
  sequence seq_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_okay_resp: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_one_wait: assert property (taken && hreadyout |=> seq_one_wait)
    else $error("wait state count wrong");
  a_rdata_hold: assert property (!rdPhase |=> $stable(hrdata))
    else $error("read data changed outside a read");
  a_open_drain: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
    else $error("line driven high");
  a_ack_at_eighth: assert property ($rose(sdaOe) |-> sclIn || bitCnt == 4'h8)
    else $error("sda pulled outside acknowledge slot");
  a_ack_held: assert property ($rose(sdaOe) && !sclIn |-> sdaOe [*4])
    else $error("acknowledge released early");
  a_req_after_ack: assert property ($rose(sclOe) |-> bitCnt == 4'h9 || bitCnt == 4'h0)
    else $error("scl held at wrong bit");
  a_scl_release: assert property ($fell(sclOe) |-> sinceCmd <= 4'h6)
    else $error("scl released without command");
  a_no_start_busy: assert property ($rose(sdaOe) && sclIn |-> !busyW)
    else $error("start generated on busy bus");
endmodule // isac_checker

bind isac_top isac_checker i_chk (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
  .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe));

// file: tb/isac_bus_master_model.sv
// far-side bus master: start, byte with acknowledge read, stop
// assumes open-drain wires resolved in the bench, pulled up when released
`timescale 1ns/100ps
module isac_bus_master_model (
  input logic sclWire,
  input logic sdaWire,
  output logic mSclLow,
  output logic mSdaLow
);
  initial begin
    mSclLow = 1'b0;
    mSdaLow = 1'b0;
  end
  // slave may stretch scl; bounded so a stuck line cannot hang the run
  task automatic pulse(output logic s);
    int n;
    mSclLow = 1'b0;
    for (n = 0; n < 200 && sclWire !== 1'b1; n++) #5;
    #16;
    s = sdaWire;
    #16;
  endtask
  task automatic start_cond;
    mSdaLow = 1'b1;
    #32;
    mSclLow = 1'b1;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    int i;
    logic s;
    for (i = 7; i >= 0; i--) begin
      #16;
      mSdaLow = !b[i];
      #16;
      pulse(s);
      mSclLow = 1'b1;
    end
    #16;
    mSdaLow = 1'b0;
    #16;
    pulse(ack);
    mSclLow = 1'b1;
  endtask
  task automatic stop_cond;
    logic s;
    #16;
    mSdaLow = 1'b1;
    #16;
    pulse(s);
    mSdaLow = 1'b0;
    #32;
  endtask
endmodule // isac_bus_master_model

// file: tb/testbench.sv
// self-checking bench for isac_top: register bus driver and link scenarios
// assumes isac_checker is bound and isac_bus_master_model plays the far side
`timescale 1ns/100ps
`include "isac_map.svh"
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready, hreadyout, hresp, sclOut, sclOe, sdaOut, sdaOe;
  logic sclWire, sdaWire, mSclLow, mSdaLow;
  int err_total = 0;
  int checked = 0;
  always #2.5 clk = ~clk;
  assign hready = hreadyout;
  assign sclWire = !(sclOe || mSclLow);
  assign sdaWire = !(sdaOe || mSdaLow);
  isac_top i_dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sclIn(sclWire),
    .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe));
  isac_bus_master_model i_mst (.sclWire(sclWire), .sdaWire(sdaWire), .mSclLow(mSclLow),
    .mSdaLow(mSdaLow));
  task automatic summarize;
    if (err_total == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bail(input string what);
    err_total++;
    $display("unexpected %s expected done seen timeout", what);
    summarize();
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) bail("bus answer");
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    ahb(1'b1, a, {24'h0, d}, r);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
    input string what);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(what, {24'h0, e}, r & {24'hffffff, m});
  endtask
  // waits for sclOe (which=0) or sdaOe (which=1) to reach v
  task automatic wait_lvl(input logic which, input logic v);
    int n;
    for (n = 0; n < 3000 && (which ? sdaOe : sclOe) !== v; n++) @(posedge clk);
    if ((which ? sdaOe : sclOe) !== v) bail("line level");
  endtask
  task automatic frame(input logic [7:0] b, input logic ackExp, input logic [7:0] stExp);
    logic ack;
    i_mst.start_cond();
    i_mst.send_byte(b, ack);
    chk("ack", {31'h0, ackExp}, {31'h0, ack});
    // service request lands a few clocks after the ninth fall, past the synchroniser
    repeat (8) @(posedge clk);
    rdc(`ISAC_OFF_STATUS, 8'hfe, stExp, "status");
  endtask
  task automatic finish_frame(input logic acked);
    repeat (8) @(posedge clk);
    if (acked) begin
      chk("scl hold", 32'h1, {31'h0, sclOe});
      wr(`ISAC_OFF_CMD, 8'h18);
      // the release leaves the output flop on the same edge that completes the write
      repeat (2) @(posedge clk);
      chk("scl hold", 32'h0, {31'h0, sclOe});
    end
    i_mst.stop_cond();
    rdc(`ISAC_OFF_STATUS, 8'hfe, 8'h10, "status");
  endtask
  task automatic t_regs;
    rdc(`ISAC_OFF_STATUS, 8'hff, 8'h10, "status reset");
    rdc(`ISAC_OFF_OWN_ADDR, 8'hff, 8'h00, "own address reset");
    rdc(8'h20, 8'hff, 8'h00, "unmapped");
    wr(`ISAC_OFF_OWN_ADDR, 8'ha4);
    rdc(`ISAC_OFF_OWN_ADDR, 8'hff, 8'ha4, "own address");
    wr(`ISAC_OFF_CMD, 8'h08);
  endtask
  task automatic t_match;
    logic ack;
    frame(8'ha4, 1'b0, 8'h24);
    rdc(`ISAC_OFF_STATUS, 8'h01, 8'h00, "last bit");
    wr(`ISAC_OFF_CMD, 8'h18);
    rdc(`ISAC_OFF_STATUS, 8'hfe, 8'h30, "status");
    i_mst.send_byte(8'h5b, ack);
    chk("data ack", 32'h0, {31'h0, ack});
    finish_frame(1'b1);
  endtask
  task automatic t_trx;
    logic ack;
    frame(8'ha5, 1'b0, 8'h64);
    // the clear write carries the role too, so keep transmitter selected
    wr(`ISAC_OFF_CMD, 8'h58);
    i_mst.send_byte(8'hff, ack);
    chk("master nack", 32'h1, {31'h0, ack});
    rdc(`ISAC_OFF_STATUS, 8'h01, 8'h01, "last bit");
    finish_frame(1'b1);
  endtask
  task automatic t_mismatch;
    frame(8'ha6, 1'b1, 8'h30);
    chk("scl idle", 32'h0, {31'h0, sclOe});
    wr(`ISAC_OFF_CMD, 8'ha8);
    repeat (20) @(posedge clk);
    chk("start on busy", 32'h0, {31'h0, sdaOe});
    wr(`ISAC_OFF_CMD, 8'h08);
    finish_frame(1'b0);
  endtask
  task automatic t_gcall;
    frame(8'h00, 1'b0, 8'h26);
    wr(`ISAC_OFF_CMD, 8'h18);
    rdc(`ISAC_OFF_STATUS, 8'hfe, 8'h32, "status");
    finish_frame(1'b0);
  endtask
  task automatic t_nodetect_free;
    wr(`ISAC_OFF_CONFIG, 8'h08);
    frame(8'ha4, 1'b1, 8'h30);
    finish_frame(1'b0);
    frame(8'h00, 1'b1, 8'h30);
    finish_frame(1'b0);
    wr(`ISAC_OFF_OWN_ADDR, 8'ha5);
    frame(8'h3c, 1'b0, 8'h20);
    finish_frame(1'b1);
    wr(`ISAC_OFF_OWN_ADDR, 8'ha4);
    wr(`ISAC_OFF_CONFIG, 8'h00);
  endtask
  task automatic t_softreset;
    frame(8'ha4, 1'b0, 8'h24);
    wr(`ISAC_OFF_CMD, 8'h0a);
    wr(`ISAC_OFF_CMD, 8'h09);
    rdc(`ISAC_OFF_STATUS, 8'hff, 8'h10, "status");
    chk("lines released", 32'h0, {30'h0, sclOe, sdaOe});
    rdc(`ISAC_OFF_OWN_ADDR, 8'hff, 8'h00, "own address");
    i_mst.stop_cond();
    wr(`ISAC_OFF_OWN_ADDR, 8'ha4);
    frame(8'ha4, 1'b0, 8'h24);
    finish_frame(1'b1);
  endtask
  task automatic t_master;
    wr(`ISAC_OFF_CMD, 8'he8);
    wait_lvl(1'b0, 1'b1);
    chk("start sda", 32'h1, {31'h0, sdaOe});
    rdc(`ISAC_OFF_STATUS, 8'he0, 8'he0, "status");
    wr(`ISAC_OFF_CMD, 8'hc8);
    wait_lvl(1'b1, 1'b0);
    rdc(`ISAC_OFF_STATUS, 8'h20, 8'h00, "status");
    // disable only once status has shown the bus free
    wr(`ISAC_OFF_CMD, 8'h00);
    repeat (2) @(posedge clk);
    chk("lines idle", 32'h0, {30'h0, sclOe, sdaOe});
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_match();
    t_trx();
    t_mismatch();
    t_gcall();
    t_nodetect_free();
    t_softreset();
    t_master();
    summarize();
  end
endmodule // testbench
